// *** logic/debug_port_select.v ***
`timescale 1ns/1ps
`include "dbg_port_defs.vh"

module debug_port_select (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_tck,
  input wire i_tck_drv,
  input wire i_tms,
  input wire i_tms_drv,
  input wire i_tdi,
  input wire i_tdi_drv,
  input wire i_tdo_bit,
  input wire i_trig_event,
  output reg o_tdi,
  output reg o_tdi_oe,
  output reg o_tdo,
  output reg o_trigger_output,
  output reg o_trigger_output_oe,
  output reg o_mode,
  output reg o_tms_bit,
  output reg o_tdi_bit,
  output reg o_tck_rise,
  output reg [6:0] o_wr_addr,
  output reg [7:0] o_wr_data,
  output reg o_wr_strobe
);

  // ****************************************
  // Pin levels with pull-ups
  // ****************************************
  // undriven reads high
  wire tck_pin = i_tck_drv ? i_tck : 1'b1;
  wire tms_pin = i_tms_drv ? i_tms : 1'b1;
  wire tdi_pin = i_tdi_drv ? i_tdi : 1'b1;

  // ****************************************
  // Synchronisers
  // ****************************************
  reg [1:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg tck_d;
  reg tdi_d;
  // async clock sampled through two flops
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tck_s <= 2'h3;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      tck_d <= 1'b1;
      tdi_d <= 1'b1;
    end else begin
      tck_s <= {tck_s[0], tck_pin};
      tms_s <= {tms_s[0], tms_pin};
      tdi_s <= {tdi_s[0], tdi_pin};
      tck_d <= tck_s[1];
      // Last data level, kept apart from the shifter for start detection
      tdi_d <= tdi_s[1];
    end
  end

  wire rise = tck_s[1] & ~tck_d;
  wire fall = ~tck_s[1] & tck_d;

  // ****************************************
  // Mode capture after reset
  // ****************************************
  reg mode_done;
  reg [1:0] settle;
  // strap caught once the synchroniser holds the pin
  // held until next reset
  // Sync flops reset high, so reading them at once would always pick two-wire
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_done <= 1'b0;
      settle <= 2'h0;
      o_mode <= `MODE_INSTR;
    end else if (!mode_done) begin
      if (settle == 2'h2) begin
        mode_done <= 1'b1;
        o_mode <= tck_s[1] ? `MODE_TWO_WIRE : `MODE_INSTR;
      end else
        settle <= settle + 2'h1;
    end
  end

  wire instr_on = mode_done & (o_mode == `MODE_INSTR);
  wire twi_on = mode_done & (o_mode == `MODE_TWO_WIRE);

  // ****************************************
  // Instrumentation port sampling
  // ****************************************
  // mode select on rising edge
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tms_bit <= 1'b1;
      o_tdi_bit <= 1'b1;
      o_tck_rise <= 1'b0;
      o_tdo <= 1'b0;
    end else begin
      o_tck_rise <= instr_on & rise;
      if (instr_on & rise) begin
        o_tms_bit <= tms_s[1];
        o_tdi_bit <= tdi_s[1];
      end
      if (instr_on & fall)
        o_tdo <= i_tdo_bit;
    end
  end

  // ****************************************
  // Trigger output
  // ****************************************
  // event copied one cycle late, high as long as the event
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_trigger_output <= 1'b0;
      o_trigger_output_oe <= 1'b0;
    end else begin
      o_trigger_output <= instr_on & i_trig_event;
      o_trigger_output_oe <= instr_on & i_trig_event;
    end
  end

  // ****************************************
  // Two-wire multi-byte write receiver
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_SEP = 2'h2;
  localparam ST_DATA = 2'h3;
  reg [1:0] state;
  reg [3:0] count;
  reg [7:0] shift;
  reg write_cmd;
  reg addr_step;
  // Start is data falling while clock high
  wire start = twi_on & tck_s[1] & tck_d & tdi_d & ~tdi_s[1];

  // Shift one serial bit in at the bottom
  function [7:0] shift_in;
    input [7:0] cur;
    input bit_in;
    begin
      shift_in = {cur[6:0], bit_in};
    end
  endfunction

  // test clock is the serial clock
  // data-in read as serial data line
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      count <= 4'h0;
      shift <= 8'hFF;
      write_cmd <= 1'b0;
      addr_step <= 1'b0;
      o_wr_addr <= 7'h00;
      o_wr_data <= 8'h00;
      o_wr_strobe <= 1'b0;
      o_tdi <= 1'b0;
      o_tdi_oe <= 1'b0;
    end else begin
      o_wr_strobe <= 1'b0;
      o_tdi <= 1'b0;
      o_tdi_oe <= 1'b0; // Device only listens on writes
      if (start) begin
        state <= ST_ADDR;
        count <= 4'h0;
        shift <= 8'hFF;
        addr_step <= 1'b0;
      end else if (twi_on & rise) begin
        if (state == ST_IDLE)
          shift <= shift_in(shift, tdi_s[1]);
        else if (state == ST_ADDR) begin
          shift <= shift_in(shift, tdi_s[1]);
          if (count == `ADDR_BITS) begin
            o_wr_addr <= shift[6:0];
            write_cmd <= ~tdi_s[1]; // Low bit selects write
            addr_step <= 1'b0;
            state <= ST_SEP;
            count <= 4'h0;
          end else
            count <= count + 4'h1;
        end else if (state == ST_SEP) begin
          // further bytes need no command
          // Step late so the address stands with its own strobe
          if (addr_step)
            o_wr_addr <= o_wr_addr + 7'h01;
          addr_step <= 1'b0;
          state <= ST_DATA;
          count <= 4'h0;
        end else begin
          shift <= shift_in(shift, tdi_s[1]);
          if (count == `DATA_BITS - 4'h1) begin
            o_wr_data <= shift_in(shift, tdi_s[1]);
            o_wr_strobe <= write_cmd;
            addr_step <= 1'b1;
            state <= ST_SEP;
            count <= 4'h0;
          end else
            count <= count + 4'h1;
        end
      end
    end
  end

endmodule // debug_port_select

// *** logic/dbg_port_defs.vh ***
`ifndef DBG_PORT_DEFS_VH
`define DBG_PORT_DEFS_VH
// Mode latched on the third clock after reset release
`define MODE_INSTR 1'b0
`define MODE_TWO_WIRE 1'b1
// Two-wire frame lengths
`define ADDR_BITS 4'h7
`define DATA_BITS 4'h8
// Trigger pulse length in system clocks; unused, the trigger stays high as long as the event
`define TRIG_CYCLES 4'h1
`endif

// *** tb/dbg_chk_asserts.sv ***
`timescale 1ns/1ps
// ****
// Port checks
// ****
module dbg_chk (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_tck,
  input wire o_tdi_oe,
  input wire o_tdo,
  input wire o_trigger_output,
  input wire o_trigger_output_oe,
  input wire o_mode,
  input wire o_tck_rise,
  input wire o_wr_strobe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_mode_held: assert property ($past(i_resetn, 4) |-> $stable(o_mode)) else $error("mode");
  a_trig_release: assert property (o_trigger_output_oe == o_trigger_output) else $error("oe");
  a_trig_pulse: assert property (o_trigger_output |=> !o_trigger_output) else $error("trig");
  a_tdo_fall: assert property ($changed(o_tdo) |-> !$past(i_tck, 2)) else $error("tdo");
  a_rise_high: assert property (o_tck_rise && !o_mode && $past(i_resetn, 4) |-> $past(i_tck, 2)) else $error("rise");
  a_tdi_input: assert property (!o_mode |-> !o_tdi_oe) else $error("tdi");
  a_wr_mode: assert property (o_wr_strobe |-> o_mode) else $error("wr");
  a_wr_gap: assert property (o_wr_strobe |=> !o_wr_strobe [*8]) else $error("gap");
  cover property (o_wr_strobe);
  cover property (o_trigger_output);
  cover property (o_tck_rise && !o_mode);
endmodule // dbg_chk
bind debug_port_select dbg_chk dbg_chk_inst (.*);

// *** tb/dbg_host.sv ***
`timescale 1ns/1ps
// ****
// Debug host
// ****
module dbg_host (
  output wire o_tck,
  output wire o_tck_drv,
  output wire o_tms,
  output wire o_tms_drv,
  output wire o_tdi,
  output wire o_tdi_drv
);
  logic [2:0] v = 3'h7;
  logic [2:0] d = 3'h0;
  // released pins show the inverse, so only a pull-up reads one
  assign {o_tck, o_tms, o_tdi} = v ^ ~d;
  assign {o_tck_drv, o_tms_drv, o_tdi_drv} = d;
  // Clock strap, data released
  task automatic strap(input logic dk, input logic lv);
    d = {dk, 2'h0};
    v[2] = lv;
  endtask
  // one bit per 32 ns, data set while clock low
  task automatic bit1(input logic [1:0] dv, input logic [1:0] x);
    d = {1'h1, dv};
    v[1:0] = x;
    #8 v[2] = 1'h1;
    #16 v[2] = 1'h0;
    #8;
  endtask
  task automatic byte8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit1(2'h3, {1'h1, b[i]});
  endtask
  // start, address, write bit, bytes, clock parked low
  task automatic frame(input logic [6:0] ad, input logic [7:0] b, input int n);
    d = 3'h7;
    v = 3'h7;
    #16 v[0] = 1'h0;
    #16 v[2] = 1'h0;
    byte8({ad, 1'h0});
    repeat (n) begin
      bit1(2'h3, 2'h3);
      byte8(b);
      b += 8'h25;
    end
  endtask
endmodule // dbg_host

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb;
  logic i_clk_sys = 1'h0, i_resetn = 1'h0, i_tdo_bit = 1'h0, i_trig_event = 1'h0;
  wire i_tck, i_tck_drv, i_tms, i_tms_drv, i_tdi, i_tdi_drv, h_tdi, h_drv, o_tdi, o_tdi_oe, o_tdo;
  wire o_trigger_output, o_trigger_output_oe, o_mode, o_tms_bit, o_tdi_bit, o_tck_rise, o_wr_strobe;
  wire [6:0] o_wr_addr;
  wire [7:0] o_wr_data;
  int failures = 0, n_checks = 0, cyc = 0, ntrig = 0;
  logic [31:0] rs = 32'h1F, a;
  logic [15:0] q[$];
  // Data line level from both enables
  assign i_tdi = o_tdi_oe ? o_tdi : h_tdi;
  assign i_tdi_drv = h_drv | o_tdi_oe;
  debug_port_select debug_port_select_inst (.*);
  dbg_host dbg_host_inst (.o_tck(i_tck), .o_tck_drv(i_tck_drv), .o_tms(i_tms), .o_tms_drv(i_tms_drv),
    .o_tdi(h_tdi), .o_tdi_drv(h_drv));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2 i_clk_sys = ~i_clk_sys;
  // Random tdo, model queue compared at each result
  always @(negedge i_clk_sys) begin
    cyc++;
    ntrig += o_trigger_output;
    if (o_tck_rise && !o_mode) chk({o_tms_bit, o_tdi_bit}, q.pop_front());
    if (o_wr_strobe) chk({o_wr_addr, o_wr_data}, q.pop_front());
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  // Instrumentation mode, then two-wire writes
  initial begin
    dbg_host_inst.strap(1'h1, 1'h0);
    repeat (5) @(negedge i_clk_sys);
    i_resetn = 1'h1;
    repeat (8) @(negedge i_clk_sys);
    chk(o_mode, 1'h0);
    #1.3;
    for (int k = 0; k < 12; k++) begin
      a = xs();
      q.push_back(a[2] ? a[1:0] : 2'h3);
      i_tdo_bit = a[3];
      dbg_host_inst.bit1({2{a[2]}}, a[1:0]);
      repeat (3) @(negedge i_clk_sys);
      chk(o_tdo, a[3]);
    end
    repeat (3) begin
      @(negedge i_clk_sys) i_trig_event = 1'h1;
      @(negedge i_clk_sys) i_trig_event = 1'h0;
      repeat (6) @(negedge i_clk_sys);
    end
    chk(ntrig, 3);
    chk(o_mode, 1'h0);
    i_resetn = 1'h0;
    dbg_host_inst.strap(1'h0, 1'h1);
    repeat (5) @(negedge i_clk_sys);
    i_resetn = 1'h1;
    repeat (8) @(negedge i_clk_sys);
    chk(o_mode, 1'h1);
    #1.3;
    for (int j = 0; j < 2; j++) begin
      a = xs();
      for (int k = 0; k < 3 - 2 * j; k++) q.push_back({a[6:0] + 7'(k), a[15:8] + 8'(k * 37)});
      dbg_host_inst.frame(a[6:0], a[15:8], 3 - 2 * j);
      #100;
    end
    chk(q.size(), 0);
    chk(o_mode, 1'h1);
    summarize();
  end
endmodule // tb
